// ==== hw/rxfs_pkg.sv ====
// constants and types for the receive filter and status block
// Operation
// - save-errored bit keeps bad frames, status written
// - accept-runts takes 8..63 byte frames
// - broadcast and multicast enables OR with station match
// - promiscuous takes any physical destination
// - monitor checks frames, counts missed, never buffers
// - good frame gets status byte written when a buffer is free and monitor is off
// - rejected errored frame gets no status write
// - status bits 5:0 cleared when next frame arrives
// - intact bit only when all error bits clear
// - crc mismatch sets crc bit, counts as crc unless odd end makes it an alignment error
// - fifo overflow sets overrun, aborts frame
// - missed bit when no buffers or monitor
// - address type: 0 physical, 1 group
// - receiver disabled follows monitor mode
// - deferring follows carrier sense or collision
// - crc/alignment pair never reads 10
package rxfs_pkg;
    localparam logic [31:0] RXFS_RX_OFS = 32'h0000000c;
    localparam int CFG_SEP = 0;
    localparam int CFG_AR = 1;
    localparam int CFG_AB = 2;
    localparam int CFG_AM = 3;
    localparam int CFG_PRO = 4;
    localparam int CFG_MON = 5;
    localparam logic [7:0] CFG_WR_MASK = 8'h3f;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] ST_RST = 8'h00;
    localparam logic [15:0] LEN_MIN_FULL = 16'h0040;
    localparam logic [15:0] LEN_MIN_RUNT = 16'h0008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // frame summary from the receive datapath at end of frame
    typedef struct packed {
        logic [47:0] dest;
        logic [15:0] len;
        logic crc_ok;
        logic odd_end;
    } rxfs_pkt_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] status;
        logic fo_pend;
        logic [1:0] cs_sync1;
        logic [1:0] cs_sync2;
        logic aw_got;
        logic [31:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pkt_accept;
        logic status_wr;
        logic [7:0] status_byte;
        logic abort_rx;
        logic inc_align;
        logic inc_crc;
        logic inc_missed;
    } rxfs_state_t;
endpackage

// ==== hw/rxfs_top.sv ====
// receive acceptance filter, receive status and axi4-lite slave
//
// The AXI4-Lite register port was decided locally.
module rxfs_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // receive datapath
    input wire logic rx_start,
    input wire logic rx_done,
    input wire rxfs_pkg::rxfs_pkt_t rx_pkt,
    input wire logic rx_overrun,
    input wire logic rx_buf_avail,
    input wire logic [47:0] station_addr,
    input wire logic [63:0] mcast_hash,
    input wire logic [5:0] hash_index,
    // transceiver pins
    input wire logic carrier_sense_in,
    input wire logic collision_in,
    // results
    output logic pkt_accept,
    output logic status_wr,
    output logic [7:0] status_byte,
    output logic abort_rx,
    output logic inc_align,
    output logic inc_crc,
    output logic inc_missed
);
    rxfs_pkg::rxfs_state_t s, n;

    logic is_bcast, is_mcast, hash_hit, phys_ok, addr_match;
    logic too_short, is_runt, len_ok, crc_bad, fae, err_ok;
    logic recog, missed_packet, keep, fo_now, frame_ok;
    logic [7:0] st_new;

    // register decode, shared by both channels
    function automatic logic reg_hit(input logic [31:0] a);
        return a == rxfs_pkg::RXFS_RX_OFS;
    endfunction

    always_comb begin
        is_bcast = &rx_pkt.dest;
        is_mcast = rx_pkt.dest[0] && !is_bcast;
        hash_hit = mcast_hash[hash_index];
        phys_ok = !rx_pkt.dest[0]
            && (s.cfg[rxfs_pkg::CFG_PRO] || rx_pkt.dest == station_addr);
        addr_match = phys_ok
            || (s.cfg[rxfs_pkg::CFG_AB] && is_bcast)
            || (s.cfg[rxfs_pkg::CFG_AM] && is_mcast && hash_hit);
        too_short = rx_pkt.len < rxfs_pkg::LEN_MIN_RUNT;
        is_runt = rx_pkt.len < rxfs_pkg::LEN_MIN_FULL;
        len_ok = !too_short && (!is_runt || s.cfg[rxfs_pkg::CFG_AR]);
        crc_bad = !rx_pkt.crc_ok;
        fae = crc_bad && rx_pkt.odd_end;
        err_ok = !crc_bad || s.cfg[rxfs_pkg::CFG_SEP];
        fo_now = s.fo_pend || rx_overrun;
        recog = addr_match && len_ok;
        frame_ok = recog && err_ok && !fo_now;
        missed_packet = frame_ok && (s.cfg[rxfs_pkg::CFG_MON] || !rx_buf_avail);
        keep = frame_ok && !missed_packet;
        st_new = {s.status[7:6], is_bcast || is_mcast, missed_packet, fo_now, fae, crc_bad,
            !(crc_bad || fae || fo_now || missed_packet)};
    end

    always_comb begin
        n = s;
        n.pkt_accept = 1'b0;
        n.status_wr = 1'b0;
        n.abort_rx = 1'b0;
        n.inc_align = 1'b0;
        n.inc_crc = 1'b0;
        n.inc_missed = 1'b0;
        n.cs_sync1 = {carrier_sense_in, collision_in};
        n.cs_sync2 = s.cs_sync1;
        n.status[7] = |s.cs_sync2;
        n.status[6] = s.cfg[rxfs_pkg::CFG_MON];
        if (rx_overrun) begin
            n.fo_pend = 1'b1;
            n.abort_rx = 1'b1;
        end else if (rx_start) begin
            n.fo_pend = 1'b0;
        end
        if (rx_start) begin
            n.status[5:0] = 6'h00;
        end
        if (rx_done && !too_short) begin
            n.status[5:0] = st_new[5:0];
            // overrun in this cycle still wins
            n.fo_pend = rx_overrun;
            n.inc_crc = crc_bad && !fae;
            n.inc_align = fae;
            n.inc_missed = missed_packet;
            n.pkt_accept = keep;
            n.status_wr = keep;
            n.status_byte = st_new;
        end

        // axi write: address and data taken in any order
        if (awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
            n.awready = 1'b0;
        end
        if (wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = wdata[7:0];
            n.wstrb0 = wstrb[0];
            n.wready = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = rxfs_pkg::RESP_SLVERR;
            if (reg_hit(s.awaddr)) begin
                n.bresp = rxfs_pkg::RESP_OKAY;
                if (s.wstrb0) begin
                    n.cfg = s.wdata & rxfs_pkg::CFG_WR_MASK;
                end
            end
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // axi read
        if (arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            if (reg_hit(araddr)) begin
                n.rdata = {24'h000000, s.status};
                n.rresp = rxfs_pkg::RESP_OKAY;
            end else begin
                n.rdata = 32'h00000000;
                n.rresp = rxfs_pkg::RESP_SLVERR;
            end
        end
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.cfg <= rxfs_pkg::CFG_RST;
            s.status <= rxfs_pkg::ST_RST;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign pkt_accept = s.pkt_accept;
    assign status_wr = s.status_wr;
    assign status_byte = s.status_byte;
    assign abort_rx = s.abort_rx;
    assign inc_align = s.inc_align;
    assign inc_crc = s.inc_crc;
    assign inc_missed = s.inc_missed;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_runt_short;
        rx_done && too_short |=> !pkt_accept && !status_wr;
    endproperty
    a_runt_short: assert property (p_runt_short) else $error("frame under 8 bytes taken");

    property p_err_reject;
        rx_done && crc_bad && !s.cfg[rxfs_pkg::CFG_SEP] |=> !status_wr && !pkt_accept;
    endproperty
    a_err_reject: assert property (p_err_reject) else $error("rejected bad frame got status");

    property p_monitor;
        rx_done && s.cfg[rxfs_pkg::CFG_MON] |=> !pkt_accept;
    endproperty
    a_monitor: assert property (p_monitor) else $error("frame buffered in monitor mode");

    property p_intact;
        s.status[0] |-> s.status[4:1] == 4'h0;
    endproperty
    a_intact: assert property (p_intact) else $error("intact bit with error bit");

    property p_no_10;
        s.status[2:1] != 2'h2 && !(status_wr && status_byte[2:1] == 2'h2);
    endproperty
    a_no_10: assert property (p_no_10) else $error("alignment without crc bit");

    property p_clear;
        rx_start && !rx_done |=> s.status[5:0] == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared at arrival");

    property p_dis;
        ##1 s.status[6] == $past(s.cfg[rxfs_pkg::CFG_MON]);
    endproperty
    a_dis: assert property (p_dis) else $error("disabled bit not tracking monitor");

    property p_defer;
        (carrier_sense_in || collision_in) [*3] |=> s.status[7];
    endproperty
    a_defer: assert property (p_defer) else $error("deferring bit not set");

    property p_phys_reject;
        rx_done && !rx_pkt.dest[0] && !s.cfg[rxfs_pkg::CFG_PRO] && rx_pkt.dest != station_addr
            |=> !pkt_accept;
    endproperty
    a_phys_reject: assert property (p_phys_reject) else $error("foreign station frame taken");

    property p_overrun;
        rx_overrun |=> abort_rx ##0 s.fo_pend;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_crc_tally;
        rx_done && !too_short && crc_bad && !fae |=> inc_crc && s.status[1];
    endproperty
    a_crc_tally: assert property (p_crc_tally) else $error("crc error not flagged or counted");

    property p_align_tally;
        rx_done && !too_short && fae |=> inc_align && s.status[2:1] == 2'h3;
    endproperty
    a_align_tally: assert property (p_align_tally) else $error("alignment error not flagged or counted");

    property p_missed;
        rx_done && !too_short && missed_packet |=> inc_missed && s.status[4] && !pkt_accept;
    endproperty
    a_missed: assert property (p_missed) else $error("missed frame not flagged or counted");

    property p_addr_type;
        rx_done && !too_short |=> s.status[5] == $past(rx_pkt.dest[0]);
    endproperty
    a_addr_type: assert property (p_addr_type) else $error("address type bit wrong");

    property p_keep;
        rx_done && !too_short && keep |=> pkt_accept && status_wr && status_byte[5:0] == s.status[5:0];
    endproperty
    a_keep: assert property (p_keep) else $error("kept frame status byte not written");

    property p_fo_status;
        rx_done && !too_short && fo_now |=> s.status[3] && !pkt_accept && !status_wr;
    endproperty
    a_fo_status: assert property (p_fo_status) else $error("overrun frame not aborted");

    property p_runt_take;
        rx_done && !too_short && is_runt && !s.cfg[rxfs_pkg::CFG_AR] |=> !pkt_accept;
    endproperty
    a_runt_take: assert property (p_runt_take) else $error("runt taken with runts refused");

    c_accept: cover property (rx_done ##1 pkt_accept);
    c_missed: cover property (rx_done ##1 inc_missed);
    c_align: cover property (rx_done ##1 inc_align);
    c_overrun: cover property (rx_overrun ##1 abort_rx);
    c_defer: cover property (collision_in ##3 s.status[7]);
endmodule

// ==== verif/rxfs_phy_model.sv ====
// receive datapath and transceiver stand-in for the filter bench
module rxfs_phy_model (
    // clock
    input wire logic aclk,
    // frame side
    output logic rx_start,
    output logic rx_done,
    output rxfs_pkg::rxfs_pkt_t rx_pkt,
    output logic rx_overrun,
    // pins
    output logic carrier_sense_in,
    output logic collision_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rx_start, rx_done, rx_overrun, carrier_sense_in, collision_in} = '0;
        rx_pkt = '0;
    end
    // one frame: start, optional overflow, end with summary
    task automatic send(input logic [47:0] d, input logic [15:0] l, input logic ok, od, ov);
        @(posedge aclk);
        rx_start <= 1'b1;
        carrier_sense_in <= 1'b1;
        @(posedge aclk);
        rx_start <= 1'b0;
        rx_overrun <= ov;
        @(posedge aclk);
        rx_overrun <= 1'b0;
        rx_pkt <= '{d, l, ok, od};
        rx_done <= 1'b1;
        @(posedge aclk);
        rx_done <= 1'b0;
        carrier_sense_in <= 1'b0;
        // summary no longer valid, show its inverse
        rx_pkt <= ~rx_pkt;
    endtask
    task automatic col(input logic v);
        @(posedge aclk);
        collision_in <= v;
    endtask
endmodule

// ==== verif/rxfs_top_tb.sv ====
// self-checking bench for the receive filter and status block
module rxfs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] STA = 48'h665544332210;
    localparam logic [47:0] OTH = 48'h665544332212;
    localparam logic [47:0] BC = 48'hffffffffffff;
    localparam logic [47:0] MC = 48'h0000005e0001;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic rx_start, rx_done, rx_overrun, rx_buf_avail, carrier_sense_in, collision_in;
    logic pkt_accept, status_wr, abort_rx, inc_align, inc_crc, inc_missed;
    logic [7:0] status_byte;
    logic [47:0] station_addr;
    logic [63:0] mcast_hash;
    logic [5:0] hash_index;
    rxfs_pkg::rxfs_pkt_t rx_pkt;
    int failures = 0;
    int n_compared = 0;
    int n_abort = 0;
    rxfs_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .rx_start(rx_start), .rx_done(rx_done), .rx_pkt(rx_pkt),
        .rx_overrun(rx_overrun), .rx_buf_avail(rx_buf_avail), .station_addr(station_addr),
        .mcast_hash(mcast_hash), .hash_index(hash_index), .carrier_sense_in(carrier_sense_in),
        .collision_in(collision_in), .pkt_accept(pkt_accept), .status_wr(status_wr),
        .status_byte(status_byte), .abort_rx(abort_rx), .inc_align(inc_align), .inc_crc(inc_crc),
        .inc_missed(inc_missed));
    rxfs_phy_model phy (.aclk(aclk), .rx_start(rx_start), .rx_done(rx_done), .rx_pkt(rx_pkt),
        .rx_overrun(rx_overrun), .carrier_sense_in(carrier_sense_in), .collision_in(collision_in));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(negedge aclk) if (abort_rx === 1'b1) n_abort++;
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tmo();
        failures++;
        wrap_up();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [31:0] a, d);
        logic ta, tw, tb;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic axr(input logic [31:0] a);
        logic ta, tr;
        int n;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            {ta, tr, rd, rs} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
        rready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic cfg(input logic [7:0] v);
        axw(32'h0000000c, {24'h0, v});
        chk("bresp", {30'h0, rxfs_pkg::RESP_OKAY}, {30'h0, rs});
    endtask
    // eo is accept, status write, align, crc, missed
    task automatic fr(input logic [47:0] d, input logic [15:0] l, input logic ok, od, ov, input logic [4:0] eo,
        input logic [5:0] es);
        phy.send(d, l, ok, od, ov);
        #1;
        chk("outputs", {27'h0, eo}, {27'h0, pkt_accept, status_wr, inc_align, inc_crc, inc_missed});
        if (eo[3]) chk("status_byte", {26'h0, es}, {26'h0, status_byte[5:0]});
    endtask
    task automatic s_err();
        cfg(8'h00);
        fr(STA, 16'h0040, 1'b0, 1'b0, 1'b0, 5'b00010, 6'h00);
        axr(32'h0000000c);
        chk("status", 32'h02, {26'h0, rd[5:0]});
        cfg(8'h01);
        fr(STA, 16'h0040, 1'b0, 1'b1, 1'b0, 5'b11100, 6'h06);
        fr(STA, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h01);
    endtask
    task automatic s_filt();
        cfg(8'h00);
        fr(STA, 16'h003f, 1'b1, 1'b0, 1'b0, 5'b00000, 6'h00);
        fr(BC, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b00000, 6'h00);
        fr(OTH, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b00000, 6'h00);
        cfg(8'h02);
        fr(STA, 16'h0008, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h01);
        cfg(8'hc4);
        fr(BC, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h21);
        cfg(8'h08);
        mcast_hash <= 64'h20;
        fr(MC, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h21);
        mcast_hash <= 64'hffffffffffffffdf;
        fr(MC, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b00000, 6'h00);
        cfg(8'h1c);
        mcast_hash <= '1;
        hash_index <= 6'h3a;
        fr(MC, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h21);
        fr(OTH, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b11000, 6'h01);
    endtask
    task automatic s_miss();
        cfg(8'h20);
        fr(STA, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b00001, 6'h00);
        axr(32'h0000000c);
        chk("status", 32'h50, {25'h0, rd[6:0]});
        cfg(8'h00);
        axr(32'h0000000c);
        chk("disabled", 32'h0, {31'h0, rd[6]});
        rx_buf_avail <= 1'b0;
        fr(STA, 16'h0040, 1'b1, 1'b0, 1'b0, 5'b00001, 6'h00);
        rx_buf_avail <= 1'b1;
        fr(STA, 16'h0040, 1'b1, 1'b0, 1'b1, 5'b00000, 6'h00);
        chk("abort", 32'h1, n_abort);
        axr(32'h0000000c);
        chk("status", 32'h08, {26'h0, rd[5:0]});
    endtask
    task automatic s_bus();
        phy.col(1'b1);
        repeat (4) @(posedge aclk);
        axr(32'h0000000c);
        chk("deferring", 32'h1, {31'h0, rd[7]});
        phy.col(1'b0);
        repeat (4) @(posedge aclk);
        axr(32'h0000000c);
        chk("deferring", 32'h0, {31'h0, rd[7]});
        axr(32'h00000010);
        chk("rresp", {30'h0, rxfs_pkg::RESP_SLVERR}, {30'h0, rs});
        chk("rdata", 32'h0, rd);
        axw(32'h00000010, 32'h00000020);
        chk("bresp", {30'h0, rxfs_pkg::RESP_SLVERR}, {30'h0, rs});
        axr(32'h0000000c);
        chk("disabled", 32'h0, {31'h0, rd[6]});
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        {mcast_hash, rx_buf_avail} = 65'h1;
        station_addr = STA;
        hash_index = 6'h05;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        s_err();
        s_filt();
        s_miss();
        s_bus();
        wrap_up();
    end
endmodule
